// file: src/pressure_port.sv
// I2C target with measurement control, calibration and result registers
`timescale 1ns/1ps
`default_nettype none
`include "pressure_port_params.svh"

module pressure_port
	import pressure_port_pkg::*;
#(
	parameter int CONV_TEMP_CYC = $rtoi(`CONV_TEMP_MS * `CLK_FREQ_KHZ),
	parameter int CONV_P0_CYC = $rtoi(`CONV_P0_MS * `CLK_FREQ_KHZ),
	parameter int CONV_P1_CYC = $rtoi(`CONV_P1_MS * `CLK_FREQ_KHZ),
	parameter int CONV_P2_CYC = $rtoi(`CONV_P2_MS * `CLK_FREQ_KHZ),
	parameter int CONV_P3_CYC = $rtoi(`CONV_P3_MS * `CLK_FREQ_KHZ),
	parameter int TMR_W = 24,
	parameter logic [8*`CALIB_BYTES-1:0] CALIB_DATA = {`CALIB_WORDS{16'h1234}},
	// Identity value is arbitrary
	parameter logic [7:0] DEVICE_ID = 8'ha7
) (
	// Clock and reset
	input wire logic i_clk_sys,
	input wire logic i_srst,
	// I2C pins
	input wire logic i_scl,
	output logic o_scl_o,
	output logic o_scl_oe,
	input wire logic i_sda,
	output logic o_sda_o,
	output logic o_sda_oe,
	// Conversion front end
	output logic o_conv_start,
	output logic o_conv_pressure,
	output logic [1:0] o_conv_oss,
	input wire logic [23:0] i_conv_result
);

	// ************************************************************
	// Parameter checks
	// ************************************************************
	if (CONV_TEMP_CYC < 1 || CONV_P0_CYC < 1 || CONV_P1_CYC < 1 ||
		CONV_P2_CYC < 1 || CONV_P3_CYC < 1) begin : g_chk_min
		$error("Conversion counts must be at least one cycle");
	end
	if (TMR_W > 31 || CONV_TEMP_CYC >= (1 << TMR_W) || CONV_P0_CYC >= (1 << TMR_W) ||
		CONV_P1_CYC >= (1 << TMR_W) || CONV_P2_CYC >= (1 << TMR_W) ||
		CONV_P3_CYC >= (1 << TMR_W)) begin : g_chk_max
		$error("Conversion counts exceed timer width");
	end

	// ************************************************************
	// Pin synchronisers and bus conditions
	// ************************************************************
	logic [2:0] scl_reg;
	logic [2:0] scl_next;
	logic [2:0] sda_reg;
	logic [2:0] sda_next;
	logic scl_rise;
	logic scl_fall;
	logic start_det;
	logic stop_det;

	always_comb begin
		scl_next = {scl_reg[1:0], i_scl};
		sda_next = {sda_reg[1:0], i_sda};
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			scl_reg <= 3'h7;
			sda_reg <= 3'h7;
		end else begin
			scl_reg <= scl_next;
			sda_reg <= sda_next;
		end
	end

	assign scl_rise = scl_reg[1] && !scl_reg[2];
	assign scl_fall = !scl_reg[1] && scl_reg[2];
	assign start_det = scl_reg[1] && scl_reg[2] && !sda_reg[1] && sda_reg[2];
	assign stop_det = scl_reg[1] && scl_reg[2] && sda_reg[1] && !sda_reg[2];

	// ************************************************************
	// Calibration store
	// ************************************************************
	logic [7:0] calib_rom [0:`CALIB_BYTES-1];

	for (genvar g = 0; g < `CALIB_BYTES; g++) begin : g_calib
		assign calib_rom[g] = CALIB_DATA[8*(`CALIB_BYTES-g)-1 -: 8];
	end

	// ************************************************************
	// Register state and read multiplexer
	// ************************************************************
	logic [7:0] ctrl_reg;
	logic [7:0] ctrl_next;
	logic [7:0] res_hi_reg;
	logic [7:0] res_hi_next;
	logic [7:0] res_mid_reg;
	logic [7:0] res_mid_next;
	logic [7:0] res_xlo_reg;
	logic [7:0] res_xlo_next;
	logic [TMR_W-1:0] tmr_reg;
	logic [TMR_W-1:0] tmr_next;
	logic start_reg;
	logic start_next;
	logic press_reg;
	logic press_next;
	logic [1:0] oss_reg;
	logic [1:0] oss_next;
	logic [7:0] ptr_reg;
	logic [7:0] rd_byte;
	logic [7:0] calib_idx;

	assign calib_idx = ptr_reg - `REG_CALIB_FIRST;

	always_comb begin
		rd_byte = `READ_UNMAPPED;
		if (ptr_reg >= `REG_CALIB_FIRST && ptr_reg <= `REG_CALIB_LAST) begin
			rd_byte = calib_rom[calib_idx[4:0]];
		end else begin
			unique case (ptr_reg)
				`REG_IDENTITY: rd_byte = DEVICE_ID;
				`REG_MEAS_CTRL: rd_byte = ctrl_reg;
				`REG_RES_HIGH: rd_byte = res_hi_reg;
				`REG_RES_MID: rd_byte = res_mid_reg;
				`REG_RES_XLOW: rd_byte = res_xlo_reg;
				default: rd_byte = `READ_UNMAPPED;
			endcase
		end
	end

	// ************************************************************
	// I2C target engine
	// ************************************************************
	i2c_state_e state_reg;
	i2c_state_e state_next;
	logic [3:0] cnt_reg;
	logic [3:0] cnt_next;
	logic [7:0] shift_reg;
	logic [7:0] shift_next;
	logic [7:0] ptr_next;
	logic rw_reg;
	logic rw_next;
	logic first_reg;
	logic first_next;
	logic oe_reg;
	logic oe_next;
	logic wr_en;

	always_comb begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		shift_next = shift_reg;
		ptr_next = ptr_reg;
		rw_next = rw_reg;
		first_next = first_reg;
		oe_next = oe_reg;
		wr_en = 1'b0;
		if (start_det) begin
			state_next = S_ADDR;
			cnt_next = 4'd0;
			oe_next = 1'b0;
			first_next = 1'b1;
		end else if (stop_det) begin
			state_next = S_IDLE;
			oe_next = 1'b0;
		end else begin
			unique case (state_reg)
				S_IDLE: begin
					oe_next = 1'b0;
				end
				S_ADDR, S_WRITE: begin
					if (scl_rise && cnt_reg != `BYTE_BITS) begin
						shift_next = {shift_reg[6:0], sda_reg[1]};
						cnt_next = cnt_reg + 4'd1;
					end else if (scl_fall && cnt_reg == `BYTE_BITS) begin
						if (state_reg == S_ADDR) begin
							if (shift_reg[7:1] == `TARGET_ADDR) begin
								rw_next = shift_reg[0];
								state_next = S_ACK;
								oe_next = 1'b1;
							end else begin
								state_next = S_IDLE;
							end
						end else begin
							if (first_reg) begin
								ptr_next = shift_reg;
							end else begin
								wr_en = 1'b1;
								ptr_next = ptr_reg + 8'h01;
							end
							first_next = 1'b0;
							state_next = S_ACK;
							oe_next = 1'b1;
						end
					end
				end
				S_ACK: begin
					if (scl_fall) begin
						cnt_next = 4'd0;
						oe_next = 1'b0;
						state_next = S_WRITE;
						if (rw_reg) begin
							shift_next = rd_byte;
							oe_next = !rd_byte[7];
							cnt_next = 4'd1;
							state_next = S_READ;
						end
					end
				end
				S_READ: begin
					if (scl_fall) begin
						if (cnt_reg == `BYTE_BITS) begin
							oe_next = 1'b0;
							state_next = S_RACK;
							ptr_next = ptr_reg + 8'h01;
						end else begin
							oe_next = !shift_reg[6];
							shift_next = {shift_reg[6:0], 1'b0};
							cnt_next = cnt_reg + 4'd1;
						end
					end
				end
				S_RACK: begin
					if (scl_rise && sda_reg[1]) begin
						state_next = S_IDLE;
					end else if (scl_fall) begin
						shift_next = rd_byte;
						oe_next = !rd_byte[7];
						cnt_next = 4'd1;
						state_next = S_READ;
					end
				end
			endcase
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			state_reg <= S_IDLE;
			cnt_reg <= 4'd0;
			shift_reg <= 8'h00;
			ptr_reg <= 8'h00;
			rw_reg <= 1'b0;
			first_reg <= 1'b0;
			oe_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			shift_reg <= shift_next;
			ptr_reg <= ptr_next;
			rw_reg <= rw_next;
			first_reg <= first_next;
			oe_reg <= oe_next;
		end
	end

	// ************************************************************
	// Control, conversion timer and result registers
	// ************************************************************
	logic soft_rst;

	assign soft_rst = wr_en && ptr_reg == `REG_SOFT_RESET && shift_reg == `SOFT_RESET_KEY;

	always_comb begin
		ctrl_next = ctrl_reg;
		res_hi_next = res_hi_reg;
		res_mid_next = res_mid_reg;
		res_xlo_next = res_xlo_reg;
		tmr_next = tmr_reg;
		start_next = 1'b0;
		press_next = press_reg;
		oss_next = oss_reg;
		if (soft_rst) begin
			ctrl_next = `CTRL_RESET;
			res_hi_next = `RES_HIGH_RESET;
			res_mid_next = `RES_MID_RESET;
			res_xlo_next = `RES_XLOW_RESET;
			tmr_next = '0;
			press_next = 1'b0;
			oss_next = 2'd0;
		end else if (wr_en && ptr_reg == `REG_MEAS_CTRL) begin
			ctrl_next = shift_reg;
			tmr_next = '0;
			if (shift_reg[`SCO_BIT]) begin
				start_next = 1'b1;
				press_next = shift_reg[`MEAS_SEL_MSB:0] != `MEAS_TEMP_CODE;
				oss_next = shift_reg[`OSS_MSB:`OSS_LSB];
				if (!press_next) begin
					tmr_next = TMR_W'(CONV_TEMP_CYC);
				end else begin
					unique case (oss_next)
						2'd0: tmr_next = TMR_W'(CONV_P0_CYC);
						2'd1: tmr_next = TMR_W'(CONV_P1_CYC);
						2'd2: tmr_next = TMR_W'(CONV_P2_CYC);
						2'd3: tmr_next = TMR_W'(CONV_P3_CYC);
					endcase
				end
			end
		end else if (ctrl_reg[`SCO_BIT]) begin
			if (tmr_reg <= TMR_W'(1)) begin
				res_hi_next = i_conv_result[23:16];
				res_mid_next = i_conv_result[15:8];
				res_xlo_next = i_conv_result[7:0] & `RES_XLOW_MASK;
				ctrl_next[`SCO_BIT] = 1'b0;
				tmr_next = '0;
			end else begin
				tmr_next = tmr_reg - TMR_W'(1);
			end
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			ctrl_reg <= `CTRL_RESET;
			res_hi_reg <= `RES_HIGH_RESET;
			res_mid_reg <= `RES_MID_RESET;
			res_xlo_reg <= `RES_XLOW_RESET;
			tmr_reg <= '0;
			start_reg <= 1'b0;
			press_reg <= 1'b0;
			oss_reg <= 2'd0;
		end else begin
			ctrl_reg <= ctrl_next;
			res_hi_reg <= res_hi_next;
			res_mid_reg <= res_mid_next;
			res_xlo_reg <= res_xlo_next;
			tmr_reg <= tmr_next;
			start_reg <= start_next;
			press_reg <= press_next;
			oss_reg <= oss_next;
		end
	end

	// ************************************************************
	// Outputs
	// ************************************************************
	assign o_sda_o = 1'b0;
	assign o_sda_oe = oe_reg;
	assign o_scl_o = 1'b0;
	assign o_scl_oe = 1'b0;
	assign o_conv_start = start_reg;
	assign o_conv_pressure = press_reg;
	assign o_conv_oss = oss_reg;

endmodule
`default_nettype wire

// file: src/pressure_port_params.svh
// Constants of the pressure sensor I2C register port
`ifndef PRESSURE_PORT_PARAMS_SVH
`define PRESSURE_PORT_PARAMS_SVH

`define TARGET_ADDR 7'h77
`define REG_CALIB_FIRST 8'haa
`define REG_CALIB_LAST 8'hbf
`define REG_IDENTITY 8'hd0
`define REG_SOFT_RESET 8'he0
`define REG_MEAS_CTRL 8'hf4
`define REG_RES_HIGH 8'hf6
`define REG_RES_MID 8'hf7
`define REG_RES_XLOW 8'hf8
`define SOFT_RESET_KEY 8'hb6
`define READ_UNMAPPED 8'h00
`define CTRL_RESET 8'h00
`define RES_HIGH_RESET 8'h80
`define RES_MID_RESET 8'h00
`define RES_XLOW_RESET 8'h00
`define RES_XLOW_MASK 8'hf8
`define SCO_BIT 5
`define OSS_MSB 7
`define OSS_LSB 6
`define MEAS_SEL_MSB 4
`define MEAS_TEMP_CODE 5'h0e
`define BYTE_BITS 4'd8
`define CALIB_BYTES 22
`define CALIB_WORDS 11
`define CLK_FREQ_KHZ 250000
`define CONV_TEMP_MS 4.5
`define CONV_P0_MS 4.5
`define CONV_P1_MS 7.5
`define CONV_P2_MS 13.5
`define CONV_P3_MS 25.5

`endif

// file: src/pressure_port_pkg.sv
// Types of the pressure sensor I2C register port
`default_nettype none
package pressure_port_pkg;
	typedef enum logic [2:0] {
		S_IDLE,
		S_ADDR,
		S_ACK,
		S_WRITE,
		S_READ,
		S_RACK
	} i2c_state_e;
endpackage
`default_nettype wire

// file: sim/pressure_port_assertions.sv
// Pin checks for the pressure sensor I2C register port
`timescale 1ns/1ps
`default_nettype none
module pressure_port_assertions (
	// Clock and reset
	input wire logic i_clk_sys,
	input wire logic i_srst,
	// I2C pins
	input wire logic i_scl,
	input wire logic o_scl_o,
	input wire logic o_scl_oe,
	input wire logic i_sda,
	input wire logic o_sda_o,
	input wire logic o_sda_oe,
	// Conversion front end
	input wire logic o_conv_start,
	input wire logic o_conv_pressure,
	input wire logic [1:0] o_conv_oss,
	input wire logic [23:0] i_conv_result
);
	// ****************
	// Assertions
	// ****************
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (i_srst);
	a_sda_only_low: assert property (o_sda_o == 1'b0)
		else $error("SDA driven high");
	a_scl_left_free: assert property (!o_scl_oe && !o_scl_o)
		else $error("SCL driven");
	a_sda_moves_low: assert property ($changed(o_sda_oe) |-> !i_scl)
		else $error("SDA moved while SCL high");
	a_sda_pull_bounded: assert property ($rose(o_sda_oe) |-> ##[1:130] !o_sda_oe)
		else $error("SDA held low too long");
	a_start_single: assert property (o_conv_start |=> !o_conv_start)
		else $error("Start pulse too long");
	a_oss_on_start: assert property ($changed(o_conv_oss) |->
		o_conv_start || $past(o_conv_start) || o_conv_oss == 2'b00)
		else $error("Oversampling changed without start");
	a_kind_on_start: assert property ($changed(o_conv_pressure) |->
		o_conv_start || $past(o_conv_start) || !o_conv_pressure)
		else $error("Kind changed without start");
	a_reset_quiet: assert property (disable iff (1'b0) i_srst |=>
		!o_sda_oe && !o_conv_start && !o_conv_pressure && o_conv_oss == 2'b00)
		else $error("Outputs active after reset");
endmodule
`default_nettype wire

// file: sim/i2c_host_model.sv
// Host controller model driving the I2C pins as open drain
`timescale 1ns/1ps
`default_nettype none
module i2c_host_model (
	// Clock and bus
	input wire logic i_clk,
	input wire logic i_sda,
	// Pull controls, high pulls the line low
	output logic o_scl_pull,
	output logic o_sda_pull
);
	initial begin
		o_scl_pull = 1'b0;
		o_sda_pull = 1'b0;
	end
	task automatic wait_cyc(input int n);
		repeat (n) @(posedge i_clk);
	endtask
	// One bit per 12 cycles, SDA moves mid low phase
	task automatic bit_io(input logic b, output logic r);
		wait_cyc(3);
		o_sda_pull <= !b;
		wait_cyc(3);
		o_scl_pull <= 1'b0;
		wait_cyc(6);
		r = i_sda;
		o_scl_pull <= 1'b1;
	endtask
	task automatic send_start();
		wait_cyc(3);
		o_sda_pull <= 1'b0;
		wait_cyc(3);
		o_scl_pull <= 1'b0;
		wait_cyc(6);
		o_sda_pull <= 1'b1;
		wait_cyc(6);
		o_scl_pull <= 1'b1;
	endtask
	task automatic send_stop();
		wait_cyc(3);
		o_sda_pull <= 1'b1;
		wait_cyc(3);
		o_scl_pull <= 1'b0;
		wait_cyc(6);
		o_sda_pull <= 1'b0;
		wait_cyc(6);
	endtask
	task automatic byte_io(input logic [7:0] d, input logic a, output logic [7:0] q, output logic k);
		for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
		bit_io(a, k);
	endtask
endmodule
`default_nettype wire

// file: sim/tb_pressure_sensor_i2c_register_port.sv
// Register-level bench for the pressure sensor I2C register port
`timescale 1ns/1ps
`default_nettype none
module tb_pressure_sensor_i2c_register_port;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic [23:0] res = 24'h000000;
	logic scl_pull, sda_pull, sda_oe, scl_oe, conv_start, conv_p, k;
	logic [1:0] conv_oss;
	logic [7:0] q;
	logic [7:0] rbuf [0:21];
	int compares = 0;
	int mismatches = 0;
	int pulses = 0;
	int epul = 0;
	logic [7:0] codes [5] = '{8'h2e, 8'h34, 8'h74, 8'hb4, 8'hf4};
	int cyc [5] = '{800, 800, 900, 1000, 1100};
	wire logic scl_w = !(scl_pull | scl_oe);
	wire logic sda_w = !(sda_pull | sda_oe);
	always #2 clk = ~clk;
	always @(posedge clk) if (conv_start === 1'b1) pulses++;
	pressure_port #(.CONV_TEMP_CYC(800), .CONV_P0_CYC(800), .CONV_P1_CYC(900), .CONV_P2_CYC(1000),
		.CONV_P3_CYC(1100)) u_dut (.i_clk_sys(clk), .i_srst(srst), .i_scl(scl_w),
		.o_scl_o(), .o_scl_oe(scl_oe), .i_sda(sda_w), .o_sda_o(), .o_sda_oe(sda_oe),
		.o_conv_start(conv_start), .o_conv_pressure(conv_p), .o_conv_oss(conv_oss), .i_conv_result(res));
	i2c_host_model u_host (.i_clk(clk), .i_sda(sda_w), .o_scl_pull(scl_pull), .o_sda_pull(sda_pull));
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic addr(input logic [7:0] r);
		u_host.send_start();
		u_host.byte_io(8'hee, 1'b1, q, k);
		chk({7'h0, k}, 8'h00);
		u_host.byte_io(r, 1'b1, q, k);
		chk({7'h0, k}, 8'h00);
	endtask
	task automatic wr(input logic [7:0] r, input logic [7:0] d);
		addr(r);
		u_host.byte_io(d, 1'b1, q, k);
		chk({7'h0, k}, 8'h00);
		u_host.send_stop();
	endtask
	task automatic rd(input logic [7:0] r, input int n);
		addr(r);
		u_host.send_start();
		u_host.byte_io(8'hef, 1'b1, q, k);
		chk({7'h0, k}, 8'h00);
		for (int i = 0; i < n; i++) u_host.byte_io(8'hff, i == n - 1, rbuf[i], k);
		u_host.send_stop();
	endtask
	task automatic rd1(input logic [7:0] r, input logic [7:0] e);
		rd(r, 1);
		chk(rbuf[0], e);
	endtask
	task automatic end_sim();
		$display("compares=%0d mismatches=%0d", compares, mismatches);
		if (mismatches == 0 && compares > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	initial begin
		repeat (16) @(posedge clk);
		srst <= 1'b0;
		repeat (4) @(posedge clk);
		rd(8'hf6, 3);
		chk(rbuf[0], 8'h80);
		chk(rbuf[1], 8'h00);
		chk(rbuf[2], 8'h00);
		rd1(8'hf4, 8'h00);
		// Identity value is arbitrary
		rd1(8'hd0, 8'ha7);
		rd1(8'he0, 8'h00);
		rd1(8'hf7, 8'h00);
		rd(8'haa, 22);
		for (int i = 0; i < 22; i++) chk(rbuf[i], i[0] ? 8'h34 : 8'h12);
		for (int j = 0; j < 5; j++) begin
			res <= {codes[j], ~codes[j], 8'h5f};
			wr(8'hf4, codes[j]);
			epul++;
			chk(pulses[7:0], epul[7:0]);
			chk({5'h0, conv_p, conv_oss}, {5'h0, codes[j] != 8'h2e, codes[j][7:6]});
			rd1(8'hf4, codes[j]);
			repeat (cyc[j]) @(posedge clk);
			rd1(8'hf4, codes[j] & 8'hdf);
			rd(8'hf6, 3);
			chk(rbuf[0], codes[j]);
			chk(rbuf[1], ~codes[j]);
			chk(rbuf[2], 8'h58);
			rd1(8'hf8, 8'h58);
		end
		wr(8'hf4, 8'h14);
		chk(pulses[7:0], epul[7:0]);
		rd1(8'hf4, 8'h14);
		wr(8'he0, 8'h00);
		rd1(8'hf6, 8'hf4);
		wr(8'he0, 8'hb6);
		rd(8'hf6, 3);
		chk(rbuf[0], 8'h80);
		chk(rbuf[1], 8'h00);
		rd1(8'hf4, 8'h00);
		wr(8'hf4, 8'h14);
		srst <= 1'b1;
		repeat (16) @(posedge clk);
		srst <= 1'b0;
		repeat (4) @(posedge clk);
		rd1(8'hf4, 8'h00);
		chk(pulses[7:0], epul[7:0]);
		u_host.send_start();
		u_host.byte_io(8'h90, 1'b1, q, k);
		chk({7'h0, k}, 8'h01);
		u_host.byte_io(8'hf4, 1'b1, q, k);
		u_host.byte_io(8'h2e, 1'b1, q, k);
		chk({7'h0, k}, 8'h01);
		u_host.send_stop();
		chk(pulses[7:0], epul[7:0]);
		end_sim();
	end
	initial begin
		repeat (100000) @(posedge clk);
		mismatches++;
		end_sim();
	end
endmodule
bind pressure_port pressure_port_assertions u_chk (.i_clk_sys(i_clk_sys), .i_srst(i_srst), .i_scl(i_scl),
	.o_scl_o(o_scl_o), .o_scl_oe(o_scl_oe), .i_sda(i_sda), .o_sda_o(o_sda_o), .o_sda_oe(o_sda_oe),
	.o_conv_start(o_conv_start), .o_conv_pressure(o_conv_pressure), .o_conv_oss(o_conv_oss),
	.i_conv_result(i_conv_result));
`default_nettype wire
